// File: csw_top.sv
// Behaviour
// - software may select any of six sources
// - primary submode fixed by configuration input
// - switching and monitor only when configured zero
// - disabled: ignore new select, report initial source
// - disabled: switch request held at zero
// - equal sources: clear request, abort switch
// - valid switch start clears lock and fail
// - start source, await startup timer and lock where each applies
// - count ten new-source cycles before changeover
// - changeover clears request, copies new to current
// - stop old source, keep watchdog or crystal
// - processor keeps running during the switch
// - monitor keeps low-power RC running except sleep
// - failure raises trap, falls back to fast RC
// - fallback keeps multiplier when it was used
//
// The address map and the AXI4-Lite interface to the registers were left to the implementer.
`timescale 1ns/100ps
`default_nettype none
`include "csw_defs.svh"

module csw_top #(
  parameter logic [31:0] KEY_FIRST = 32'h0000005A,  // arbitrary value
  parameter logic [31:0] KEY_SECOND = 32'h000000C3, // arbitrary value
  parameter int STARTUP_EDGES = 1024,
  parameter int STARTUP_W = 11,
  parameter int FAIL_TICKS = 4,
  parameter int FAIL_W = 3
) (
  input wire logic mclk,
  input wire logic srst,
  input wire logic [3:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [3:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic switch_monitor_cfg,
  input wire logic monitor_enable_cfg,
  input wire logic [2:0] initial_source_cfg,
  input wire logic [1:0] primary_submode_cfg,
  input wire logic watchdog_enable,
  input wire logic sleep_mode,
  input wire logic [3:0] osc_clk,
  input wire logic sys_clk_sample,
  input wire logic multiplier_locked,
  output logic [3:0] osc_enable,
  output logic multiplier_enable,
  output logic [2:0] clock_select,
  output logic [1:0] primary_submode,
  output logic clock_fail_trap
);

  // ----------------------------------------
  // state and decoded conditions
  // ----------------------------------------
  csw_pkg::csw_top_state_t s;
  csw_pkg::csw_top_state_t next_s;
  csw_pkg::csw_src_t init_src;
  logic sw_en;
  logic monitor_on;
  logic new_edge;
  logic sys_edge;
  logic rc_edge;
  logic startup_done;
  logic ten_done;
  logic timeout_done;
  logic fail;
  logic ready;
  logic new_clk;
  logic [31:0] ctrl_word;
  logic [31:0] status_word;

  assign init_src = csw_pkg::csw_src_t'(initial_source_cfg);
  assign sw_en = ~switch_monitor_cfg;
  assign monitor_on = sw_en & monitor_enable_cfg & ~sleep_mode;
  // a select change may add one stray edge; harmless to the counts
  assign new_clk = osc_clk[csw_pkg::csw_phys(s.new_sel)];

  // failure when no system edge within the rc timeout
  assign fail = monitor_on & timeout_done & ~s.fail_trap;

  // crystal waits for startup timer, multiplier for lock
  assign ready = (~s.need_startup | startup_done) &
                 (~csw_pkg::csw_is_mult(s.new_sel) | s.lock);

  // ----------------------------------------
  // edge detectors and counters
  // ----------------------------------------
  csw_edge_det u_new_edge (
    .mclk(mclk),
    .srst(srst),
    .level(new_clk),
    .rise(new_edge)
  );

  csw_edge_det u_sys_edge (
    .mclk(mclk),
    .srst(srst),
    .level(sys_clk_sample),
    .rise(sys_edge)
  );

  csw_edge_det u_rc_edge (
    .mclk(mclk),
    .srst(srst),
    .level(osc_clk[`CSW_OSC_LOW_POWER_RC]),
    .rise(rc_edge)
  );

  csw_counter #(.W(STARTUP_W), .LIMIT(STARTUP_EDGES)) u_startup (
    .mclk(mclk),
    .srst(srst),
    .clr(s.sw_state == csw_pkg::csw_st_idle),
    .inc(new_edge && s.sw_state == csw_pkg::csw_st_wait_ready),
    .done(startup_done)
  );

  csw_counter #(.W(`CSW_NEW_CNT_W), .LIMIT(`CSW_NEW_CLK_CYCLES)) u_ten (
    .mclk(mclk),
    .srst(srst),
    .clr(s.sw_state != csw_pkg::csw_st_count),
    .inc(new_edge),
    .done(ten_done)
  );

  // rc ticks since the last system edge
  csw_counter #(.W(FAIL_W), .LIMIT(FAIL_TICKS)) u_timeout (
    .mclk(mclk),
    .srst(srst),
    .clr(sys_edge | ~monitor_on | s.fail_trap),
    .inc(rc_edge),
    .done(timeout_done)
  );

  // ----------------------------------------
  // register views
  // ----------------------------------------
  always_comb begin
    ctrl_word = `CSW_RESET_WORD;
    ctrl_word[`CSW_CUR_MSB:`CSW_CUR_LSB] = s.cur_src;
    ctrl_word[`CSW_NEW_MSB:`CSW_NEW_LSB] = s.new_sel;
    ctrl_word[`CSW_LOCK_BIT] = s.lock;
    ctrl_word[`CSW_FAIL_BIT] = s.clk_fail;
    ctrl_word[`CSW_KEEP_BIT] = s.crystal_keep;
    ctrl_word[`CSW_REQ_BIT] = s.switch_req;
    status_word = `CSW_RESET_WORD;
    status_word[`CSW_ST_OSC_MSB:`CSW_ST_OSC_LSB] = s.osc_en;
    status_word[`CSW_ST_MULT_BIT] = s.mult_en;
    status_word[`CSW_ST_BUSY_BIT] = (s.sw_state != csw_pkg::csw_st_idle);
    status_word[`CSW_ST_STATE_MSB:`CSW_ST_STATE_LSB] = s.sw_state;
    status_word[`CSW_ST_SUB_MSB:`CSW_ST_SUB_LSB] = s.submode;
  end

  assign s_axi_awready = ~s.aw_held & ~s.bvalid;
  assign s_axi_wready = ~s.w_held & ~s.bvalid;
  assign s_axi_arready = ~s.rvalid;

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb begin
    next_s = s;
    next_s.fail_trap = 1'b0;
    next_s.lock = s.lock | (multiplier_locked & s.mult_en);
    if (s.rvalid && s_axi_rready) begin
      next_s.rvalid = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      next_s.rvalid = 1'b1;
      next_s.rresp = `CSW_RESP_OKAY;
      case (s_axi_araddr)
        `CSW_OFF_CTRL: next_s.rdata = ctrl_word;
        `CSW_OFF_UNLOCK: next_s.rdata = `CSW_RESET_WORD;
        `CSW_OFF_STATUS: next_s.rdata = status_word;
        default: begin
          next_s.rdata = `CSW_RESET_WORD;
          next_s.rresp = `CSW_RESP_SLVERR;
        end
      endcase
    end
    if (s.bvalid && s_axi_bready) begin
      next_s.bvalid = 1'b0;
    end
    if (s_axi_awvalid && s_axi_awready) begin
      next_s.aw_held = 1'b1;
      next_s.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      next_s.w_held = 1'b1;
      next_s.wdata = s_axi_wdata;
      next_s.wstrb = s_axi_wstrb;
    end
    if (s.aw_held && s.w_held) begin
      next_s.aw_held = 1'b0;
      next_s.w_held = 1'b0;
      next_s.bvalid = 1'b1;
      next_s.bresp = `CSW_RESP_OKAY;
      // any write other than the second key spends the unlock
      next_s.unlock_stage = 1'b0;
      next_s.unlock_armed = 1'b0;
      case (s.aw_addr)
        `CSW_OFF_UNLOCK: begin
          // two keys in a row open one control write
          if (s.unlock_stage && s.wdata == KEY_SECOND) begin
            next_s.unlock_armed = 1'b1;
          end else if (s.wdata == KEY_FIRST) begin
            next_s.unlock_stage = 1'b1;
          end
        end
        `CSW_OFF_CTRL: begin
          if (s.unlock_armed) begin
            // any source code; submode is not writable
            if (s.wstrb[1]) begin
              next_s.new_sel = csw_pkg::csw_src_t'(
                s.wdata[`CSW_NEW_MSB:`CSW_NEW_LSB]);
            end
            if (s.wstrb[0]) begin
              next_s.crystal_keep = s.wdata[`CSW_KEEP_BIT];
              if (!s.wdata[`CSW_FAIL_BIT]) begin
                next_s.clk_fail = 1'b0;
              end
              if (s.wdata[`CSW_REQ_BIT] && sw_en) begin
                next_s.switch_req = 1'b1;
              end
            end
          end
        end
        `CSW_OFF_STATUS: begin
        end
        default: next_s.bresp = `CSW_RESP_SLVERR;
      endcase
    end

    // the switch never stalls the processor, no hold output
    unique case (s.sw_state)
      csw_pkg::csw_st_idle: begin
        if (s.switch_req && sw_en) begin
          if (s.new_sel == s.cur_src) begin
            next_s.switch_req = 1'b0;
          end else begin
            // clear lock and fail at start
            next_s.lock = 1'b0;
            next_s.clk_fail = 1'b0;
            next_s.need_startup =
              csw_pkg::csw_is_crystal(s.new_sel, s.submode) &
              ~s.osc_en[csw_pkg::csw_phys(s.new_sel)];
            next_s.sw_state = csw_pkg::csw_st_wait_ready;
          end
        end
      end
      csw_pkg::csw_st_wait_ready: begin
        if (ready) begin
          next_s.sw_state = csw_pkg::csw_st_count;
        end
      end
      csw_pkg::csw_st_count: begin
        if (ten_done) begin
          next_s.sw_state = csw_pkg::csw_st_change;
        end
      end
      csw_pkg::csw_st_change: begin
        next_s.cur_src = s.new_sel;
        next_s.switch_req = 1'b0;
        next_s.sw_state = csw_pkg::csw_st_idle;
      end
    endcase

    if (!sw_en) begin
      next_s.cur_src = init_src;
      next_s.switch_req = 1'b0;
      next_s.sw_state = csw_pkg::csw_st_idle;
    end

    // trap and fast rc fallback; fail set wins over clears
    if (fail) begin
      next_s.fail_trap = 1'b1;
      next_s.clk_fail = 1'b1;
      next_s.switch_req = 1'b0;
      next_s.sw_state = csw_pkg::csw_st_idle;
      // keep the multiplier on the fallback
      next_s.cur_src = csw_pkg::csw_is_mult(s.cur_src) ?
        csw_pkg::csw_src_fast_rc_multiplied : csw_pkg::csw_src_fast_rc;
    end

    if (srst) begin
      next_s = '0;
      next_s.cur_src = init_src;
      next_s.new_sel = init_src;
    end

    next_s.submode = primary_submode_cfg;
    // old source stops once no longer current or new
    next_s.osc_en = 4'h0;
    next_s.osc_en[csw_pkg::csw_phys(next_s.cur_src)] = 1'b1;
    if (next_s.sw_state != csw_pkg::csw_st_idle) begin
      next_s.osc_en[csw_pkg::csw_phys(next_s.new_sel)] = 1'b1;
    end
    // monitor or watchdog keeps low-power rc alive
    if (watchdog_enable || monitor_on) begin
      next_s.osc_en[`CSW_OSC_LOW_POWER_RC] = 1'b1;
    end
    if (next_s.crystal_keep) begin
      next_s.osc_en[`CSW_OSC_LOW_POWER_CRYSTAL] = 1'b1;
    end
    next_s.mult_en = csw_pkg::csw_is_mult(next_s.cur_src) |
      ((next_s.sw_state != csw_pkg::csw_st_idle) &
       csw_pkg::csw_is_mult(next_s.new_sel));
  end

  always_ff @(posedge mclk) begin
    s <= next_s;
  end

  assign s_axi_bresp = s.bresp;
  assign s_axi_bvalid = s.bvalid;
  assign s_axi_rdata = s.rdata;
  assign s_axi_rresp = s.rresp;
  assign s_axi_rvalid = s.rvalid;
  assign osc_enable = s.osc_en;
  assign multiplier_enable = s.mult_en;
  assign clock_select = s.cur_src;
  assign primary_submode = s.submode;
  assign clock_fail_trap = s.fail_trap;

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  logic [4:0] chk_edges;

  always_ff @(posedge mclk) begin
    if (srst || s.sw_state != csw_pkg::csw_st_count) begin
      chk_edges <= 5'h00;
    end else if (new_edge && chk_edges != 5'h1F) begin
      chk_edges <= chk_edges + 5'h01;
    end
  end

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (srst);

  sequence seq_start_valid;
    s.sw_state == csw_pkg::csw_st_idle && s.switch_req && sw_en &&
    s.new_sel != s.cur_src && !fail;
  endsequence

  sequence seq_commit;
    s.sw_state == csw_pkg::csw_st_change && sw_en && !fail;
  endsequence

  chk_disabled_src: assert property (
    switch_monitor_cfg && !srst ##1 switch_monitor_cfg |->
      clock_select == $past(initial_source_cfg))
    else $error("disabled switching did not report initial source");

  chk_req_held_zero: assert property (
    switch_monitor_cfg |=> !s.switch_req)
    else $error("request bit set while switching disabled");

  chk_redundant_abort: assert property (
    s.sw_state == csw_pkg::csw_st_idle && s.switch_req && sw_en &&
    s.new_sel == s.cur_src && !fail |=>
      !s.switch_req && s.sw_state == csw_pkg::csw_st_idle)
    else $error("redundant switch not aborted");

  chk_start_clears: assert property (
    seq_start_valid |=> !s.lock && !s.clk_fail &&
      s.sw_state == csw_pkg::csw_st_wait_ready)
    else $error("switch start left lock or fail set");

  chk_wait_lock: assert property (
    s.sw_state == csw_pkg::csw_st_wait_ready && sw_en && !fail &&
    csw_pkg::csw_is_mult(s.new_sel) && !s.lock |=>
      s.sw_state == csw_pkg::csw_st_wait_ready)
    else $error("left wait before multiplier lock");

  chk_ten_cycles: assert property (
    s.sw_state == csw_pkg::csw_st_change |->
      chk_edges >= 5'(`CSW_NEW_CLK_CYCLES))
    else $error("changeover before ten new-source cycles");

  chk_commit: assert property (
    seq_commit |=> clock_select == $past(s.new_sel) && !s.switch_req)
    else $error("changeover did not commit new source");

  chk_locked_write: assert property (
    s.aw_held && s.w_held && s.aw_addr == `CSW_OFF_CTRL &&
    !s.unlock_armed && s.sw_state == csw_pkg::csw_st_idle &&
    !s.switch_req |=> $stable(s.new_sel) && !s.switch_req)
    else $error("control write accepted without unlock");

  chk_rc_kept: assert property (
    watchdog_enable || monitor_on |=>
      osc_enable[`CSW_OSC_LOW_POWER_RC])
    else $error("low-power rc stopped while needed");

  chk_fail_fallback: assert property (
    fail |=> clock_fail_trap && s.clk_fail &&
      csw_pkg::csw_phys(s.cur_src) == `CSW_OSC_FAST_RC ##1
      !clock_fail_trap)
    else $error("failure did not trap to fast rc");

  chk_mult_fallback: assert property (
    fail && csw_pkg::csw_is_mult(s.cur_src) |=>
      clock_select == csw_pkg::csw_src_fast_rc_multiplied)
    else $error("fallback lost multiplier");

endmodule

`default_nettype wire

// File: csw_defs.svh
`ifndef CSW_DEFS_SVH
`define CSW_DEFS_SVH

// ----------------------------------------
// register offsets (byte addresses)
// ----------------------------------------
`define CSW_OFF_CTRL 4'h0
`define CSW_OFF_UNLOCK 4'h4
`define CSW_OFF_STATUS 4'h8

// ----------------------------------------
// control register fields
// ----------------------------------------
`define CSW_CUR_MSB 14
`define CSW_CUR_LSB 12
`define CSW_NEW_MSB 10
`define CSW_NEW_LSB 8
`define CSW_LOCK_BIT 5
`define CSW_FAIL_BIT 3
`define CSW_KEEP_BIT 1
`define CSW_REQ_BIT 0

// ----------------------------------------
// status register fields
// ----------------------------------------
`define CSW_ST_OSC_MSB 3
`define CSW_ST_OSC_LSB 0
`define CSW_ST_MULT_BIT 4
`define CSW_ST_BUSY_BIT 5
`define CSW_ST_STATE_MSB 7
`define CSW_ST_STATE_LSB 6
`define CSW_ST_SUB_MSB 9
`define CSW_ST_SUB_LSB 8

// ----------------------------------------
// oscillator indices and bus answers
// ----------------------------------------
`define CSW_OSC_PRIMARY 2'h0
`define CSW_OSC_LOW_POWER_CRYSTAL 2'h1
`define CSW_OSC_FAST_RC 2'h2
`define CSW_OSC_LOW_POWER_RC 2'h3
`define CSW_RESP_OKAY 2'h0
`define CSW_RESP_SLVERR 2'h2
`define CSW_RESET_WORD 32'h00000000

// ----------------------------------------
// timing counts
// ----------------------------------------
`define CSW_NEW_CLK_CYCLES 10
`define CSW_NEW_CNT_W 4

`endif

// File: csw_pkg.sv
`default_nettype none

package csw_pkg;

  // ----------------------------------------
  // clock sources and submodes
  // ----------------------------------------
  typedef enum logic [2:0] {
    csw_src_fast_rc = 3'h0,
    csw_src_fast_rc_multiplied = 3'h1,
    csw_src_primary = 3'h2,
    csw_src_primary_multiplied = 3'h3,
    csw_src_low_power_crystal = 3'h4,
    csw_src_low_power_rc_osc = 3'h5
  } csw_src_t;

  typedef enum logic [1:0] {
    csw_sub_external_clock = 2'h0,
    csw_sub_crystal = 2'h1,
    csw_sub_high_speed = 2'h2,
    csw_sub_none = 2'h3
  } csw_submode_t;

  // gray order along the switch path
  typedef enum logic [1:0] {
    csw_st_idle = 2'h0,
    csw_st_wait_ready = 2'h1,
    csw_st_count = 2'h3,
    csw_st_change = 2'h2
  } csw_sw_state_t;

  typedef struct packed {
    logic aw_held;
    logic [3:0] aw_addr;
    logic w_held;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic unlock_stage;
    logic unlock_armed;
    csw_src_t new_sel;
    csw_src_t cur_src;
    logic switch_req;
    logic lock;
    logic clk_fail;
    logic crystal_keep;
    logic need_startup;
    csw_sw_state_t sw_state;
    logic [3:0] osc_en;
    logic mult_en;
    logic fail_trap;
    logic [1:0] submode;
  } csw_top_state_t;

  typedef struct packed {
    logic prev;
  } csw_edge_state_t;

  function automatic logic [1:0] csw_phys(csw_src_t src);
    case (src)
      csw_src_primary, csw_src_primary_multiplied: csw_phys = 2'h0;
      csw_src_low_power_crystal: csw_phys = 2'h1;
      csw_src_low_power_rc_osc: csw_phys = 2'h3;
      default: csw_phys = 2'h2;
    endcase
  endfunction

  function automatic logic csw_is_mult(csw_src_t src);
    csw_is_mult = (src == csw_src_fast_rc_multiplied) ||
                  (src == csw_src_primary_multiplied);
  endfunction

  function automatic logic csw_is_crystal(csw_src_t src, logic [1:0] sub);
    csw_is_crystal = (src == csw_src_low_power_crystal) ||
      (csw_phys(src) == 2'h0 &&
       (sub == csw_sub_crystal || sub == csw_sub_high_speed));
  endfunction

endpackage

`default_nettype wire

// File: csw_edge_det.sv
`timescale 1ns/100ps
`default_nettype none

// rising edge of a sampled oscillator level
module csw_edge_det (
  input wire logic mclk,
  input wire logic srst,
  input wire logic level,
  output logic rise
);

  csw_pkg::csw_edge_state_t s;
  csw_pkg::csw_edge_state_t next_s;

  always_comb begin
    next_s = s;
    next_s.prev = srst ? 1'b0 : level;
  end

  always_ff @(posedge mclk) begin
    s <= next_s;
  end

  assign rise = level & ~s.prev;

endmodule

`default_nettype wire

// File: csw_counter.sv
`timescale 1ns/100ps
`default_nettype none

// saturating event counter, done while count equals the limit
module csw_counter #(
  parameter int W = 4,
  parameter int LIMIT = 10
) (
  input wire logic mclk,
  input wire logic srst,
  input wire logic clr,
  input wire logic inc,
  output logic done
);

  typedef struct packed {
    logic [W-1:0] count;
  } csw_cnt_state_t;

  localparam logic [W-1:0] LIMIT_W = W'(LIMIT);

  csw_cnt_state_t s;
  csw_cnt_state_t next_s;

  always_comb begin
    next_s = s;
    if (srst || clr) begin
      next_s.count = '0;
    end else if (inc && s.count != LIMIT_W) begin
      next_s.count = s.count + 1'b1;
    end
  end

  always_ff @(posedge mclk) begin
    s <= next_s;
  end

  assign done = (s.count == LIMIT_W);

endmodule

`default_nettype wire

// File: csw_osc_model.sv
`timescale 1ns/100ps
`default_nettype none

// ----------------------------------------
// oscillator sources seen by the switch
// ----------------------------------------
module csw_osc_model (
  input wire logic mclk,
  input wire logic srst,
  input wire logic [3:0] osc_enable,
  input wire logic [3:0] dead,
  input wire logic multiplier_enable,
  input wire logic [2:0] clock_select,
  output logic [3:0] osc_clk,
  output logic sys_clk_sample,
  output logic multiplier_locked
);
  logic [2:0] lock_cnt;

  // a disabled or dead source stands low, never frozen high
  always_ff @(posedge mclk) begin
    if (srst) begin
      osc_clk <= 4'h0;
      lock_cnt <= 3'h0;
    end else begin
      osc_clk <= ~osc_clk & osc_enable & ~dead;
      if (!multiplier_enable)
        lock_cnt <= 3'h0;
      else if (lock_cnt != 3'h4)
        lock_cnt <= lock_cnt + 3'h1;
    end
  end

  // lock takes a few cycles so a waiting switch is seen
  assign multiplier_locked = (lock_cnt == 3'h4);

  always_comb begin
    case (clock_select)
      3'h2, 3'h3: sys_clk_sample = osc_clk[0];
      3'h4: sys_clk_sample = osc_clk[1];
      3'h5: sys_clk_sample = osc_clk[3];
      default: sys_clk_sample = osc_clk[2];
    endcase
  end
endmodule

`default_nettype wire

// File: tb.sv
`timescale 1ns/100ps
`default_nettype none

module tb;
  logic mclk = 1'b0;
  logic srst = 1'b1;
  logic [3:0] awaddr = 4'h0;
  logic [3:0] araddr = 4'h0;
  logic [3:0] dead = 4'h0;
  logic [31:0] wdata = 32'h00000000;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  logic sm_cfg = 1'b1;
  logic [2:0] init_cfg = 3'h0;
  logic [3:0] wstrb = 4'hF;
  logic wdog = 1'b0;
  logic slp = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, mult_en, mlock, trap, sys_s;
  logic [31:0] rdata, d;
  logic [1:0] bresp, rresp, psub, r;
  logic [2:0] csel, prev;
  logic [3:0] osc_clk, osc_en;
  logic [2:0] seq [5] = '{3'h4, 3'h5, 3'h0, 3'h1, 3'h2};
  int n;
  int errors = 0;
  int check_count = 0;

  always #10 mclk = ~mclk;

  csw_top #(.STARTUP_EDGES(8), .STARTUP_W(4)) i_dut (
    .mclk(mclk), .srst(srst),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .switch_monitor_cfg(sm_cfg),
    .monitor_enable_cfg(1'b1), .initial_source_cfg(init_cfg),
    .primary_submode_cfg(2'h1), .watchdog_enable(wdog),
    .sleep_mode(slp), .osc_clk(osc_clk), .sys_clk_sample(sys_s),
    .multiplier_locked(mlock), .osc_enable(osc_en),
    .multiplier_enable(mult_en), .clock_select(csel),
    .primary_submode(psub), .clock_fail_trap(trap));

  csw_osc_model i_osc (.mclk(mclk), .srst(srst), .osc_enable(osc_en),
    .dead(dead), .multiplier_enable(mult_en), .clock_select(csel),
    .osc_clk(osc_clk), .sys_clk_sample(sys_s), .multiplier_locked(mlock));

  // ----------------------------------------
  // bus and check tasks
  // ----------------------------------------
  task finish_test;
    if (errors == 0 && check_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task compare(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // handshakes sampled at the rising edge, released just after it
  task wr(input logic [3:0] a, input logic [31:0] v);
    logic aw, w, b;
    int k;
    k = 0;
    b = 1'b0;
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!b && k < 50) begin
      @(posedge mclk);
      aw = awvalid && awready;
      w = wvalid && wready;
      b = bvalid && bready;
      k++;
      if (aw) awvalid <= 1'b0;
      if (w) wvalid <= 1'b0;
      if (b) bready <= 1'b0;
    end
    if (!b) compare(32'h0, 32'h1);
    // an edge between transfers, so no strobe is driven twice at once
    @(posedge mclk);
  endtask

  task rd(input logic [3:0] a);
    logic ar, rv;
    int k;
    k = 0;
    rv = 1'b0;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (!rv && k < 50) begin
      @(posedge mclk);
      ar = arvalid && arready;
      rv = rvalid && rready;
      d = rdata;
      r = rresp;
      k++;
      if (ar) arvalid <= 1'b0;
      if (rv) rready <= 1'b0;
    end
    if (!rv) compare(32'h0, 32'h1);
    @(posedge mclk);
  endtask

  task ctl(input logic [31:0] v);
    wr(4'h4, 32'h0000005A);
    wr(4'h4, 32'h000000C3);
    wr(4'h0, v);
  endtask

  task do_reset;
    srst <= 1'b1;
    repeat (16) @(posedge mclk);
    srst <= 1'b0;
    @(posedge mclk);
  endtask

  task wait_sel(input logic [2:0] e);
    n = 0;
    while (csel !== e && n < 400) begin
      @(negedge mclk);
      n++;
    end
    @(posedge mclk);
  endtask

  task wait_trap;
    n = 0;
    while (trap !== 1'b1 && n < 200) begin
      @(negedge mclk);
      n++;
    end
    compare(32'(trap), 32'h1);
    @(posedge mclk);
  endtask

  function automatic logic [1:0] ph(input logic [2:0] s);
    case (s)
      3'h2, 3'h3: ph = 2'h0;
      3'h4: ph = 2'h1;
      3'h5: ph = 2'h3;
      default: ph = 2'h2;
    endcase
  endfunction

  // ----------------------------------------
  // tests
  // ----------------------------------------
  initial begin
    do_reset;
    compare(32'(csel), 32'h0);
    compare(32'(osc_en), 32'h4);
    wdog <= 1'b1;
    repeat (2) @(posedge mclk);
    compare(32'(osc_en), 32'hC);
    wdog <= 1'b0;
    ctl(32'h00000201);
    repeat (40) @(posedge mclk);
    rd(4'h0);
    compare(32'(d[0]), 32'h0);
    compare(32'(d[14:12]), 32'h0);
    compare(32'(csel), 32'h0);
    sm_cfg <= 1'b0;
    do_reset;
    compare(32'(psub), 32'h1);
    wr(4'h0, 32'h00000201);
    rd(4'h0);
    compare(32'(d[10:8]), 32'h0);
    // low strobe only: new select untouched, keep bit taken
    wstrb <= 4'h1;
    ctl(32'h00000503);
    rd(4'h0);
    compare(32'(d[10:8]), 32'h0);
    compare(32'(d[1]), 32'h1);
    compare(32'(osc_en[1]), 32'h1);
    wstrb <= 4'hF;
    ctl(32'h00000001);
    repeat (4) @(posedge mclk);
    rd(4'h0);
    compare(32'(d[0]), 32'h0);
    compare(32'(csel), 32'h0);
    prev = 3'h0;
    // multiplied fast rc entered and left via plain sources only
    for (int i = 0; i < 5; i++) begin
      ctl({21'h0, seq[i], 8'h01});
      wait_sel(seq[i]);
      compare(32'(csel), 32'(seq[i]));
      compare(32'(n > 15), 32'h1);
      rd(4'h0);
      compare(32'(d[14:12]), 32'(seq[i]));
      compare(32'(d[0]), 32'h0);
      compare(32'(osc_en[ph(prev)]),
        32'(ph(prev) == 2'h3 || ph(prev) == ph(seq[i])));
      prev = seq[i];
    end
    slp <= 1'b1;
    repeat (2) @(posedge mclk);
    compare(32'(osc_en[3]), 32'h0);
    slp <= 1'b0;
    dead <= 4'h1;
    wait_trap;
    wait_sel(3'h0);
    compare(32'(csel), 32'h0);
    rd(4'h0);
    compare(32'(d[3]), 32'h1);
    init_cfg <= 3'h3;
    do_reset;
    wait_trap;
    wait_sel(3'h1);
    compare(32'(csel), 32'h1);
    compare(32'(mult_en), 32'h1);
    rd(4'h8);
    compare(32'(d[4]), 32'h1);
    rd(4'hC);
    compare(32'(r), 32'h2);
    compare(d, 32'h00000000);
    finish_test;
  end

  initial begin
    #400000;
    errors++;
    finish_test;
  end
endmodule

`default_nettype wire
